// *** common/gpx_pkg.sv ***
// How it works
// - eight drive modes, analog disables both buffers
// - input only, pull combos, open drain modes
// - per pin CMOS or LVTTL input threshold
// - input and output buffers enabled separately
// - per pin slow slew-rate select
// - ports of eight pins, three ports narrower
// - all pins disabled while reset active
// - per pin mux picks port or peripheral
// - data output register drives enabled pins
// - pin state register returns pin levels
// - pin interrupts only when enabled
// - one interrupt line per port, five total
package gpx_pkg;
  localparam int NPORT = 5;
  localparam int PW = 8;
  localparam int NPIN = NPORT * PW;
  localparam int MAXPIN = 36;
  localparam int SELW = 2;
  localparam int AW = 8;
  localparam int PORTW = AW - 5;
  // ports 2 and 3 carry seven pins, port 4 carries four
  localparam logic [NPIN-1:0] PIN_MASK = 40'h0f7f7fffff;
  // per-port register offsets inside a 32-byte window
  localparam logic [4:0] R_OUT = 5'h00;
  localparam logic [4:0] R_IN = 5'h04;
  localparam logic [4:0] R_MODE = 5'h08;
  localparam logic [4:0] R_CFG = 5'h0c;
  localparam logic [4:0] R_SEL = 5'h10;
  localparam logic [4:0] R_ISTAT = 5'h14;
  localparam logic [4:0] R_ICLR = 5'h18;
  localparam logic [4:0] R_IEN = 5'h1c;
  // field positions in the config and interrupt enable words
  localparam int CFG_IE = 0;
  localparam int CFG_OE = 8;
  localparam int CFG_LVTTL = 16;
  localparam int CFG_SLOW = 24;
  localparam int IEN_EN = 0;
  localparam int IEN_FALL = 8;
  // reset values: analog mode, buffers off, port data selected
  localparam logic [31:0] RST_VAL = 32'h0000_0000;
  localparam logic [1:0] SYNC_DONE = 2'h3;
  typedef enum logic [2:0] {
    GPX_ANALOG,
    GPX_INPUT,
    GPX_PUW_PDS,
    GPX_PUS_PDW,
    GPX_OD_LO,
    GPX_OD_HI,
    GPX_STRONG,
    GPX_RES
  } gpx_mode_t;
endpackage

// *** hdl/gpx_sync.sv ***
`timescale 1ns/1ns
module gpx_sync #(
  parameter int W = 8
) (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [W-1:0] d_i, // asynchronous levels
  output logic [W-1:0] q_o // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gpx_sync_t;
  gpx_sync_t st;
  gpx_sync_t next_st;

  always_comb
  begin
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign q_o = st.s2;
endmodule

// *** hdl/gpx_pin.sv ***
`timescale 1ns/1ns
module gpx_pin
  import gpx_pkg::*;
(
  input wire gpx_pkg::gpx_mode_t mode_i, // drive mode
  input wire logic d_i, // value to drive
  input wire logic ie_i, // input buffer enable
  input wire logic oe_i, // output buffer enable
  input wire logic en_i, // pin present and out of reset
  output logic drv_en_o, // strong driver on
  output logic pu_o, // weak pull-up on
  output logic pd_o, // weak pull-down on
  output logic ie_o // input buffer on
);
  logic hi_s;
  logic lo_s;
  logic pu_w;
  logic pd_w;
  logic inb;

  always_comb
  begin
    hi_s = 1'b0;
    lo_s = 1'b0;
    pu_w = 1'b0;
    pd_w = 1'b0;
    inb = 1'b1;
    case (mode_i)
      GPX_ANALOG: inb = 1'b0;
      GPX_INPUT: inb = 1'b1;
      GPX_PUW_PDS:
      begin
        lo_s = 1'b1;
        pu_w = 1'b1;
      end
      GPX_PUS_PDW:
      begin
        hi_s = 1'b1;
        pd_w = 1'b1;
      end
      GPX_OD_LO: lo_s = 1'b1;
      GPX_OD_HI: hi_s = 1'b1;
      GPX_STRONG:
      begin
        hi_s = 1'b1;
        lo_s = 1'b1;
      end
      GPX_RES:
      begin
        pu_w = 1'b1;
        pd_w = 1'b1;
      end
      default: inb = 1'b0;
    endcase
  end

  // buffer enables gate every mode, so software can park a pin
  assign drv_en_o = en_i & oe_i & ((d_i & hi_s) | (~d_i & lo_s));
  assign pu_o = en_i & oe_i & d_i & pu_w;
  assign pd_o = en_i & oe_i & ~d_i & pd_w;
  assign ie_o = en_i & ie_i & inb;
endmodule

// *** hdl/gpx_port.sv ***
`timescale 1ns/1ns
module gpx_port
  import gpx_pkg::*;
#(
  parameter int NP = gpx_pkg::NPORT,
  parameter logic [NP*8-1:0] MASK = gpx_pkg::PIN_MASK
) (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [gpx_pkg::AW-1:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [31:0] avs_writedata_i, // write data
  input wire logic [3:0] avs_byteenable_i, // byte lanes
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall
  input wire logic [NP*8-1:0] pad_i, // pin levels
  input wire logic [NP*8*3-1:0] periph_i, // peripheral outputs
  output logic [NP*8-1:0] pad_o, // value to drive
  output logic [NP*8-1:0] pad_oe_o, // strong driver enable
  output logic [NP*8-1:0] pad_pu_o, // weak pull-up
  output logic [NP*8-1:0] pad_pd_o, // weak pull-down
  output logic [NP*8-1:0] pad_ie_o, // input buffer enable
  output logic [NP*8-1:0] pad_lvttl_o, // LVTTL threshold
  output logic [NP*8-1:0] pad_slow_o, // slow slew rate
  output logic [NP-1:0] irq_o, // per-port interrupt
  output logic irq_any_o // any port interrupt
);
  localparam int N = NP * PW;

  // refused at elaboration, before any logic is built
  if (NP < 1 || NP > (1 << PORTW))
  begin : g_bad_np
    $error("port count does not fit the address map");
  end
  if ($countones(MASK) > MAXPIN)
  begin : g_bad_mask
    $error("too many pins enabled");
  end

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [NP-1:0][PW-1:0] dout;
    logic [NP-1:0][3*PW-1:0] mode;
    logic [NP-1:0][31:0] cfg;
    logic [NP-1:0][SELW*PW-1:0] sel;
    logic [NP-1:0][PW-1:0] stat;
    logic [NP-1:0][2*PW-1:0] ien;
    logic [NP-1:0][PW-1:0] prev;
    logic [1:0] up;
  } gpx_state_t;

  gpx_state_t st;
  gpx_state_t next_st;
  logic [NP-1:0][PW-1:0] lvl;
  logic [NP-1:0][PW-1:0] clr;
  logic [31:0] rd_val;
  logic wr;

  function automatic logic hit(input logic [AW-1:0] a, input int p,
                               input logic [4:0] off);
    return a == {PORTW'(p), off};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = n[8*i +: 8];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  // unimplemented pins are tied low before sampling
  gpx_sync #(
    .W(N)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(pad_i & MASK),
    .q_o(lvl)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    next_st = st;
    rd_val = RST_VAL;
    clr = '0;
    // one wait cycle: every access completes on the second edge
    wr = avs_write_i & st.ack;
    next_st.ack = (avs_read_i | avs_write_i) & ~st.ack;
    next_st.prev = lvl;
    next_st.up = (st.up == SYNC_DONE) ? st.up : st.up + 2'h1;
    for (int p = 0; p < NP; p++)
    begin
      if (hit(avs_address_i, p, R_OUT))
        rd_val = 32'(st.dout[p]);
      if (hit(avs_address_i, p, R_IN))
        rd_val = 32'(lvl[p]);
      if (hit(avs_address_i, p, R_MODE))
        rd_val = 32'(st.mode[p]);
      if (hit(avs_address_i, p, R_CFG))
        rd_val = st.cfg[p];
      if (hit(avs_address_i, p, R_SEL))
        rd_val = 32'(st.sel[p]);
      if (hit(avs_address_i, p, R_ISTAT))
        rd_val = 32'(st.stat[p]);
      if (hit(avs_address_i, p, R_IEN))
        rd_val = 32'(st.ien[p]);
      if (wr && hit(avs_address_i, p, R_OUT))
        next_st.dout[p] = PW'(merge(32'(st.dout[p]), avs_writedata_i,
                                    avs_byteenable_i));
      if (wr && hit(avs_address_i, p, R_MODE))
        next_st.mode[p] = (3*PW)'(merge(32'(st.mode[p]), avs_writedata_i,
                                        avs_byteenable_i));
      if (wr && hit(avs_address_i, p, R_CFG))
        next_st.cfg[p] = merge(st.cfg[p], avs_writedata_i,
                               avs_byteenable_i);
      if (wr && hit(avs_address_i, p, R_SEL))
        next_st.sel[p] = (SELW*PW)'(merge(32'(st.sel[p]), avs_writedata_i,
                                          avs_byteenable_i));
      if (wr && hit(avs_address_i, p, R_IEN))
        next_st.ien[p] = (2*PW)'(merge(32'(st.ien[p]), avs_writedata_i,
                                       avs_byteenable_i));
      if (wr && hit(avs_address_i, p, R_ICLR) && avs_byteenable_i[0])
        clr[p] = avs_writedata_i[PW-1:0];
      for (int b = 0; b < PW; b++)
      begin
        // a new edge in the clearing cycle keeps the flag set
        next_st.stat[p][b] = (st.stat[p][b] & ~clr[p][b]) |
          (st.ien[p][IEN_EN+b] &
           (st.ien[p][IEN_FALL+b] ? (st.prev[p][b] & ~lvl[p][b])
                                  : (~st.prev[p][b] & lvl[p][b])));
      end
    end
    if (avs_read_i & ~st.ack)
      next_st.rdata = rd_val;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st.ack;
  assign avs_readdata_o = st.rdata;

  ////////////////////////////////////////////////////////////////////////////

  for (genvar p = 0; p < NP; p++)
  begin : g_port
    assign irq_o[p] = |(st.stat[p] & st.ien[p][IEN_EN +: PW]);
    for (genvar b = 0; b < PW; b++)
    begin : g_pin
      localparam int I = p * PW + b;
      logic en;
      logic [3:0] src;
      // reset forces every pin off at once, not one edge later
      assign en = MASK[I] & rst_n_i;
      assign src = {periph_i[2*N+I], periph_i[N+I], periph_i[I],
                    st.dout[p][b]};
      assign pad_o[I] = src[st.sel[p][SELW*b +: SELW]];
      assign pad_lvttl_o[I] = en & st.cfg[p][CFG_LVTTL+b];
      assign pad_slow_o[I] = en & st.cfg[p][CFG_SLOW+b];
      gpx_pin u_pin (
        .mode_i(gpx_mode_t'(st.mode[p][3*b +: 3])),
        .d_i(pad_o[I]),
        .ie_i(st.cfg[p][CFG_IE+b]),
        .oe_i(st.cfg[p][CFG_OE+b]),
        .en_i(en),
        .drv_en_o(pad_oe_o[I]),
        .pu_o(pad_pu_o[I]),
        .pd_o(pad_pd_o[I]),
        .ie_o(pad_ie_o[I])
      );
    end
  end

  assign irq_any_o = |irq_o;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_dout;
    wr && hit(avs_address_i, 0, R_OUT) && avs_byteenable_i[0]
      |=> st.dout[0] == $past(avs_writedata_i[PW-1:0]);
  endproperty
  a_dout: assert property (p_dout)
    else $error("output data not stored");

  property p_in;
    avs_read_i && !st.ack && hit(avs_address_i, 0, R_IN)
      |=> !avs_waitrequest_o && avs_readdata_o == 32'($past(lvl[0]));
  endproperty
  a_in: assert property (p_in)
    else $error("pin state read wrong");

  property p_sync;
    st.up == SYNC_DONE |-> lvl == $past(pad_i & MASK, 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("pin level not two stages late");

  property p_ien;
    $rose(st.stat[1][0]) |-> $past(st.ien[1][IEN_EN]);
  endproperty
  a_ien: assert property (p_ien)
    else $error("flag set while disabled");

  property p_irq;
    st.stat[1][0] && st.ien[1][IEN_EN] |-> irq_o[1] && irq_any_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("port request line mismatch");

  property p_hold;
    st.stat[1][0] && !(wr && hit(avs_address_i, 1, R_ICLR)
                       && avs_writedata_i[0] && avs_byteenable_i[0])
      |=> st.stat[1][0];
  endproperty
  a_hold: assert property (p_hold)
    else $error("flag lost without clear");

  property p_analog;
    st.mode[0][2:0] == GPX_ANALOG |-> !pad_ie_o[0] && !pad_oe_o[0]
      && !pad_pu_o[0] && !pad_pd_o[0];
  endproperty
  a_analog: assert property (p_analog)
    else $error("analog pin has a buffer on");

  property p_oe;
    !st.cfg[0][CFG_OE] |-> !pad_oe_o[0] && !pad_pu_o[0] && !pad_pd_o[0];
  endproperty
  a_oe: assert property (p_oe)
    else $error("output on while disabled");

  property p_od;
    st.mode[0][2:0] == GPX_OD_LO |-> !(pad_oe_o[0] && pad_o[0]);
  endproperty
  a_od: assert property (p_od)
    else $error("low-only drain drove high");

  property p_mux;
    st.sel[0][SELW-1:0] == 2'h0 |-> pad_o[0] == st.dout[0][0];
  endproperty
  a_mux: assert property (p_mux)
    else $error("port data not routed");

  property p_rst;
    $rose(rst_n_i) |-> pad_oe_o == '0 && pad_ie_o == '0 && irq_o == '0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("pin active at reset release");

  property p_mask;
    ((pad_oe_o | pad_ie_o | pad_pu_o | pad_pd_o) & ~MASK) == '0;
  endproperty
  a_mask: assert property (p_mask)
    else $error("absent pin enabled");

  c_irq: cover property ($rose(irq_o[1]));
  c_clr: cover property ($fell(st.stat[1][0]));
  c_rd: cover property (avs_read_i && hit(avs_address_i, 0, R_IN)
                        && !avs_waitrequest_o);
endmodule

// *** tb/gpx_ext_model.sv ***
`timescale 1ns/1ns
module gpx_ext_model (
  input wire logic clk_i, // system clock
  input wire logic [39:0] pad_i, // value driven by the port
  input wire logic [39:0] oe_i, // strong driver on
  input wire logic [39:0] pu_i, // weak pull-up on
  input wire logic [39:0] pd_i, // weak pull-down on
  input wire logic [39:0] ext_en_i, // outside driver on
  input wire logic [39:0] ext_i, // outside driver value
  output logic [39:0] lvl_o // resolved pin level
);
  logic flip = 1'b0;
  // an undriven pin wanders, so a stale level is never read back
  always_ff @(posedge clk_i)
    flip <= ~flip;
  always_comb
    for (int i = 0; i < 40; i++)
      if (oe_i[i])
        lvl_o[i] = pad_i[i];
      else if (ext_en_i[i])
        lvl_o[i] = ext_i[i];
      else if (pu_i[i] | pd_i[i])
        lvl_o[i] = pu_i[i];
      else
        lvl_o[i] = flip ^ i[0];
endmodule

// *** tb/gpio_port_with_pin_interrupts_test.sv ***
`timescale 1ns/1ns
module gpio_port_with_pin_interrupts_test;
  import gpx_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata;
  logic [31:0] rdat;
  logic wait_o;
  // line 1 and line 2 high, line 3 low
  logic [119:0] per = {40'h0, {80{1'b1}}};
  logic [39:0] pad_o, oe, pu, pd, ie, lvt, slw, lvl;
  logic [39:0] ext_en = 40'h0;
  logic [39:0] ext = 40'h0;
  logic [4:0] irq;
  logic irq_any;
  logic [2:0] md;
  logic [7:0] oe_exp [8] = '{8'h00, 8'h00, 8'h55, 8'haa,
                             8'h55, 8'haa, 8'hff, 8'h00};
  int n_errors = 0;
  int comparisons = 0;

  gpx_port u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(adr), .avs_read_i(rd_q), .avs_write_i(wr_q),
    .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
    .pad_i(lvl), .periph_i(per), .pad_o(pad_o), .pad_oe_o(oe),
    .pad_pu_o(pu), .pad_pd_o(pd), .pad_ie_o(ie),
    .pad_lvttl_o(lvt), .pad_slow_o(slw), .irq_o(irq),
    .irq_any_o(irq_any));
  gpx_ext_model u_ext (.clk_i(clk_i), .pad_i(pad_o), .oe_i(oe),
    .pu_i(pu), .pd_i(pd), .ext_en_i(ext_en), .ext_i(ext),
    .lvl_o(lvl));

  initial
    forever #50 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [39:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // holds the request until the edge where waitrequest is low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk_i);
    rd_q <= ~w;
    wr_q <= w;
    adr <= a;
    wd <= d;
    be <= b;
    @(posedge clk_i);
    while (wait_o !== 1'b0)
    begin
      n++;
      @(posedge clk_i);
    end
    // this edge takes the request, so read data is taken here too
    rdat = rdata;
    rd_q <= 1'b0;
    wr_q <= 1'b0;
    chk("wait_cycles", 40'(n), 40'h1);
    // pads only settle after the edge that stored the write
    @(negedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [39:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(nm, {8'h0, rdat}, e);
  endtask

  task automatic pins(input logic [7:0] v);
    @(posedge clk_i);
    ext[15:8] <= v;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk_i);
    chk("pads_rst", oe | pu | pd | ie | lvt | slw, 40'h0);
    chk("irq_rst", {irq_any, irq}, 40'h0);
    rst_n_i <= 1'b1;
    rdc("mode", 8'h08, 40'h0);
    rdc("cfg", 8'h0c, 40'h0);
    rdc("sel", 8'h10, 40'h0);
    rdc("ien", 8'h1c, 40'h0);
    $display("test reset done");
    wr(8'h00, 32'haa);
    wr(8'h0c, 32'h0000_ffff);
    for (int m = 0; m < 8; m++)
    begin
      md = 3'(m);
      wr(8'h08, {8'h0, {8{md}}});
      chk("oe", oe[7:0], oe_exp[m]);
      chk("ie", ie[7:0], m == 0 ? 8'h0 : 8'hff);
    end
    chk("pu", pu[7:0], 8'haa);
    chk("pd", pd[7:0], 8'h55);
    wr(8'h08, {8'h0, {8{3'h6}}});
    chk("pad", pad_o[7:0], 8'haa);
    wr(8'h0c, 32'h3c5a_00ff);
    chk("oe_off", oe[7:0], 8'h00);
    chk("lvttl", lvt[7:0], 8'h5a);
    chk("slow", slw[7:0], 8'h3c);
    bus(1'b1, 8'h0c, 32'h0000_ff00, 4'h2);
    chk("oe_be", oe[7:0], 8'hff);
    chk("lvttl_be", lvt[7:0], 8'h5a);
    $display("test modes done");
    wr(8'h00, 32'h11);
    wr(8'h10, 32'he4e4);
    chk("mux", pad_o[7:0], 8'h77);
    for (int p = 2; p < 5; p++)
    begin
      wr(8'(p * 32 + 8), {8'h0, {8{3'h6}}});
      wr(8'(p * 32 + 12), 32'h0000_ff00);
      chk("present", oe[p*8+:8], p == 4 ? 8'h0f : 8'h7f);
    end
    rdc("no_port", 8'ha0, 40'h0);
    rdc("iclr_rd", 8'h18, 40'h0);
    rdc("misalign", 8'h01, 40'h0);
    $display("test map done");
    wr(8'h24, 32'hff);
    wr(8'h28, {8'h0, {8{3'h1}}});
    wr(8'h2c, 32'h0000_00ff);
    @(posedge clk_i);
    ext_en[15:8] <= 8'hff;
    pins(8'h3e);
    rdc("in", 8'h24, 40'h3e);
    rdc("in0", 8'h04, 40'h77);
    wr(8'h3c, 32'h0000_0203);
    wr(8'h38, 32'hff);
    chk("irq_idle", irq, 40'h0);
    pins(8'h3a);
    rdc("istat_off", 8'h34, 40'h0);
    pins(8'h3b);
    chk("irq_set", {irq_any, irq}, 40'h22);
    rdc("istat_rise", 8'h34, 40'h01);
    pins(8'h39);
    repeat (20) @(posedge clk_i);
    rdc("istat_fall", 8'h34, 40'h03);
    wr(8'h3c, 32'h0);
    chk("irq_mask", irq, 40'h0);
    wr(8'h3c, 32'h0000_0203);
    chk("irq_unmask", irq, 40'h02);
    wr(8'h38, 32'h01);
    rdc("istat_clr1", 8'h34, 40'h02);
    chk("irq_hold", irq, 40'h02);
    wr(8'h38, 32'h02);
    rdc("istat_clr2", 8'h34, 40'h0);
    chk("irq_clr", {irq_any, irq}, 40'h0);
    $display("test interrupts done");
    print_verdict();
  end

  initial
  begin
    #2000000;
    n_errors++;
    print_verdict();
  end
endmodule
